// ==== design/aamr_pkg.sv ====
// Constants shared by the converter amplifier, multiplexer and result register slice
package aamr_pkg;
	// Bus geometry
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          STRB_W          = DATA_W / 8;
	localparam int          IDX_MSB         = 7;
	localparam int          IDX_LSB         = 2;
	// Register indices; byte address is four times the index
	localparam logic [5:0]  IDX_AMP_CTRL    = 6'h0B;
	localparam logic [5:0]  IDX_POS_SEL     = 6'h0C;
	localparam logic [5:0]  IDX_NEG_SEL     = 6'h0D;
	localparam logic [5:0]  IDX_RES0        = 6'h10;
	localparam logic [5:0]  IDX_RES1        = IDX_RES0 + 6'h01;
	localparam logic [5:0]  IDX_RES2        = IDX_RES0 + 6'h02;
	localparam logic [5:0]  IDX_RES3        = IDX_RES0 + 6'h03;
	localparam logic [5:0]  IDX_SAMP0       = 6'h14;
	localparam logic [5:0]  IDX_SAMP1       = IDX_SAMP0 + 6'h01;
	// Amplifier control fields
	localparam int          GAIN_MSB        = 7;
	localparam int          GAIN_LSB        = 5;
	localparam int          BIAS_MSB        = 4;
	localparam int          BIAS_LSB        = 3;
	localparam int          DUR_MSB         = 2;
	localparam int          DUR_LSB         = 1;
	localparam int          AMP_EN_BIT      = 0;
	localparam logic [7:0]  AMP_CTRL_RST    = 8'h04;
	localparam int          GAIN_CODES      = 5;
	localparam int          BIAS_CODES      = 4;
	// Sample duration in converter clock cycles per duration code
	localparam logic [1:0]  DUR_CODE_6      = 2'h0;
	localparam logic [1:0]  DUR_CODE_15     = 2'h1;
	localparam logic [1:0]  DUR_CODE_20     = 2'h2;
	localparam logic [4:0]  DUR_CYC_6       = 5'h06;
	localparam logic [4:0]  DUR_CYC_15      = 5'h0F;
	localparam logic [4:0]  DUR_CYC_20      = 5'h14;
	// Multiplexer fields and codes
	localparam int          VIA_MSB         = 7;
	localparam int          VIA_LSB         = 6;
	localparam int          SEL_MSB         = 5;
	localparam logic [1:0]  VIA_DIRECT      = 2'h0;
	localparam logic [1:0]  VIA_AMP         = 2'h1;
	localparam logic [1:0]  VIA_RST         = 2'h0;
	localparam logic [5:0]  SEL_RST         = 6'h00;
	localparam logic [5:0]  SEL_GND_DEFAULT = 6'h00;
	localparam logic [5:0]  SEL_GND         = 6'h30;
	localparam logic [5:0]  SEL_SUPPLY      = 6'h31;
	localparam logic [5:0]  SEL_TEMP        = 6'h32;
	localparam logic [5:0]  SEL_DACREF      = 6'h33;
	localparam int          POS_PINS        = 15;
	localparam int          NEG_PINS        = 7;
	// Start-trigger code for a positive selector write
	localparam logic [2:0]  START_POS_WRITE = 3'h2;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_DECERR     = 2'h3;
endpackage

// ==== design/aamr_regs.sv ====
// Amplifier control, input multiplexer and result registers behind an AXI4-Lite slave
`timescale 1ns/1ns
module aamr_regs (
	input  wire logic                           clock_i,
	input  wire logic                           reset_n_i,
	input  wire logic [aamr_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
	input  wire logic                           s_axi_awvalid_i,
	output logic                                s_axi_awready_o,
	input  wire logic [aamr_pkg::DATA_W-1:0]    s_axi_wdata_i,
	input  wire logic [aamr_pkg::STRB_W-1:0]    s_axi_wstrb_i,
	input  wire logic                           s_axi_wvalid_i,
	output logic                                s_axi_wready_o,
	output logic [1:0]                          s_axi_bresp_o,
	output logic                                s_axi_bvalid_o,
	input  wire logic                           s_axi_bready_i,
	input  wire logic [aamr_pkg::ADDR_W-1:0]    s_axi_araddr_i,
	input  wire logic                           s_axi_arvalid_i,
	output logic                                s_axi_arready_o,
	output logic [aamr_pkg::DATA_W-1:0]         s_axi_rdata_o,
	output logic [1:0]                          s_axi_rresp_o,
	output logic                                s_axi_rvalid_o,
	input  wire logic                           s_axi_rready_i,
	input  wire logic                           low_latency_ctrl_i,
	input  wire logic [2:0]                     start_trigger_sel_i,
	input  wire logic                           result_valid_i,
	input  wire logic [31:0]                    result_data_i,
	input  wire logic                           sample_valid_i,
	input  wire logic [15:0]                    sample_data_i,
	output logic                                conversion_start_o,
	output logic [aamr_pkg::GAIN_CODES-1:0]     amp_gain_sel_o,
	output logic [aamr_pkg::BIAS_CODES-1:0]     amp_bias_current_sel_o,
	output logic [4:0]                          amp_sample_duration_o,
	output logic                                amp_power_o,
	output logic                                route_direct_o,
	output logic                                route_amp_o,
	output logic                                pos_gnd_o,
	output logic [aamr_pkg::POS_PINS-1:0]       pos_analog_pin_inputs_o,
	output logic                                pos_supply_div10_input_o,
	output logic                                pos_temp_sensor_input_o,
	output logic                                pos_comparator_dac_ref_o,
	output logic                                neg_gnd_o,
	output logic [aamr_pkg::NEG_PINS-1:0]       neg_analog_pin_inputs_o,
	output logic                                neg_supply_div10_input_o,
	output logic                                neg_comparator_dac_ref_o
);
	import aamr_pkg::*;

	// Bus state
	logic                 awready_r, awready_nxt, wready_r, wready_nxt;
	logic                 aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic [5:0]           aw_idx_r, aw_idx_nxt;
	logic [7:0]           wbyte_r, wbyte_nxt;
	logic                 wstrb0_r, wstrb0_nxt;
	logic                 bvalid_r, bvalid_nxt;
	logic [1:0]           bresp_r, bresp_nxt;
	logic                 arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [DATA_W-1:0]    rdata_r, rdata_nxt;
	logic [1:0]           rresp_r, rresp_nxt;
	logic                 wr_fire;
	logic [5:0]           ar_idx;
	// Register storage
	logic [7:0]           amp_ctrl_r, amp_ctrl_nxt;
	logic [1:0]           via_r, via_nxt;
	logic [5:0]           pos_code_r, pos_code_nxt, neg_code_r, neg_code_nxt;
	logic [31:0]          result_r, result_nxt;
	logic [15:0]          sample_r, sample_nxt;
	logic                 start_r, start_nxt;

	assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
	assign ar_idx  = s_axi_araddr_i[IDX_MSB:IDX_LSB];

	// Write channel: address and data taken in either order, answered once both are in
	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt  = w_held_r;
		aw_idx_nxt  = aw_idx_r;
		wbyte_nxt   = wbyte_r;
		wstrb0_nxt  = wstrb0_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		if (s_axi_awvalid_i && awready_r) begin
			aw_held_nxt = 1'b1;
			aw_idx_nxt  = s_axi_awaddr_i[IDX_MSB:IDX_LSB];
		end
		if (s_axi_wvalid_i && wready_r) begin
			w_held_nxt = 1'b1;
			wbyte_nxt  = s_axi_wdata_i[7:0];
			wstrb0_nxt = s_axi_wstrb_i[0];
		end
		if (wr_fire) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			case (aw_idx_r)
				IDX_AMP_CTRL, IDX_POS_SEL, IDX_NEG_SEL,
				IDX_RES0, IDX_RES1, IDX_RES2, IDX_RES3,
				IDX_SAMP0, IDX_SAMP1: bresp_nxt = RESP_OKAY;
				default: bresp_nxt = RESP_DECERR;
			endcase
		end else if (bvalid_r && s_axi_bready_i) begin
			bvalid_nxt = 1'b0;
		end
		// One write at a time: no new address or data until the answer is taken
		awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
		wready_nxt  = ~w_held_nxt & ~bvalid_nxt;
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_idx_r  <= 6'h00;
			wbyte_r   <= 8'h00;
			wstrb0_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			aw_idx_r  <= aw_idx_nxt;
			wbyte_r   <= wbyte_nxt;
			wstrb0_r  <= wstrb0_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
		end
	end

	// Read channel: data muxed straight from the address at the taking edge
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (s_axi_arvalid_i && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			case (ar_idx)
				IDX_AMP_CTRL: rdata_nxt = {24'h000000, amp_ctrl_r};
				IDX_POS_SEL:  rdata_nxt = {24'h000000, via_r, pos_code_r};
				IDX_NEG_SEL:  rdata_nxt = {24'h000000, via_r, neg_code_r};
				IDX_RES0:     rdata_nxt = {24'h000000, result_r[7:0]};
				IDX_RES1:     rdata_nxt = {24'h000000, result_r[15:8]};
				IDX_RES2:     rdata_nxt = {24'h000000, result_r[23:16]};
				IDX_RES3:     rdata_nxt = {24'h000000, result_r[31:24]};
				IDX_SAMP0:    rdata_nxt = {24'h000000, sample_r[7:0]};
				IDX_SAMP1:    rdata_nxt = {24'h000000, sample_r[15:8]};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = RESP_DECERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready_i) begin
			rvalid_nxt = 1'b0;
		end
		arready_nxt = ~rvalid_nxt;
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= RESP_OKAY;
		end else begin
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	// Register file; reserved codes are kept as written and simply decode to nothing
	always_comb begin
		amp_ctrl_nxt = amp_ctrl_r;
		via_nxt      = via_r;
		pos_code_nxt = pos_code_r;
		neg_code_nxt = neg_code_r;
		result_nxt   = result_r;
		sample_nxt   = sample_r;
		start_nxt    = 1'b0;
		if (wr_fire && wstrb0_r) begin
			case (aw_idx_r)
				IDX_AMP_CTRL: amp_ctrl_nxt = wbyte_r;
				IDX_POS_SEL: begin
					via_nxt      = wbyte_r[VIA_MSB:VIA_LSB];
					pos_code_nxt = wbyte_r[SEL_MSB:0];
					start_nxt    = (start_trigger_sel_i == START_POS_WRITE);
				end
				IDX_NEG_SEL: begin
					via_nxt      = wbyte_r[VIA_MSB:VIA_LSB];
					neg_code_nxt = wbyte_r[SEL_MSB:0];
				end
				default: ;
			endcase
		end
		// Conversion paths own these; bus writes to them are dropped
		if (result_valid_i) begin
			result_nxt = result_data_i;
		end
		if (sample_valid_i) begin
			sample_nxt = sample_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			amp_ctrl_r <= AMP_CTRL_RST;
			via_r      <= VIA_RST;
			pos_code_r <= SEL_RST;
			neg_code_r <= SEL_RST;
			result_r   <= 32'h00000000;
			sample_r   <= 16'h0000;
			start_r    <= 1'b0;
		end else begin
			amp_ctrl_r <= amp_ctrl_nxt;
			via_r      <= via_nxt;
			pos_code_r <= pos_code_nxt;
			neg_code_r <= neg_code_nxt;
			result_r   <= result_nxt;
			sample_r   <= sample_nxt;
			start_r    <= start_nxt;
		end
	end

	// Decoded analog controls, registered so the analog side sees no glitches
	logic [GAIN_CODES-1:0] gain_nxt, gain_r;
	logic [BIAS_CODES-1:0] bias_nxt, bias_r;
	logic [POS_PINS-1:0]   pos_pin_nxt, pos_pin_r;
	logic [NEG_PINS-1:0]   neg_pin_nxt, neg_pin_r;
	logic [4:0]            dur_nxt, dur_r;
	logic [9:0]            misc_nxt, misc_r;

	// One-hot decodes per code, per pin
	genvar gi;
	generate
		for (gi = 0; gi < POS_PINS; gi++) begin : g_pos_pin
			assign pos_pin_nxt[gi] = (pos_code_r == 6'(gi + 1));
			if (gi < NEG_PINS) begin : g_neg_pin
				assign neg_pin_nxt[gi] = (neg_code_r == 6'(gi + 1));
			end
			if (gi < GAIN_CODES) begin : g_gain
				assign gain_nxt[gi] = (amp_ctrl_r[GAIN_MSB:GAIN_LSB] == 3'(gi));
			end
			if (gi < BIAS_CODES) begin : g_bias
				assign bias_nxt[gi] = (amp_ctrl_r[BIAS_MSB:BIAS_LSB] == 2'(gi));
			end
		end
	endgenerate

	always_comb begin
		case (amp_ctrl_r[DUR_MSB:DUR_LSB])
			DUR_CODE_6:  dur_nxt = DUR_CYC_6;
			DUR_CODE_15: dur_nxt = DUR_CYC_15;
			DUR_CODE_20: dur_nxt = DUR_CYC_20;
			default:     dur_nxt = 5'h00;
		endcase
		misc_nxt[0] = amp_ctrl_r[AMP_EN_BIT] & ((via_r == VIA_AMP) | low_latency_ctrl_i);
		misc_nxt[1] = (via_r == VIA_DIRECT);
		misc_nxt[2] = (via_r == VIA_AMP);
		misc_nxt[3] = (pos_code_r == SEL_GND_DEFAULT) | (pos_code_r == SEL_GND);
		misc_nxt[4] = (pos_code_r == SEL_SUPPLY);
		misc_nxt[5] = (pos_code_r == SEL_TEMP);
		misc_nxt[6] = (pos_code_r == SEL_DACREF);
		misc_nxt[7] = (neg_code_r == SEL_GND_DEFAULT) | (neg_code_r == SEL_GND);
		misc_nxt[8] = (neg_code_r == SEL_SUPPLY);
		misc_nxt[9] = (neg_code_r == SEL_DACREF);
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gain_r    <= 5'h01;      // Decode of the reset control byte, no step at release
			bias_r    <= 4'h1;
			pos_pin_r <= '0;
			neg_pin_r <= '0;
			dur_r     <= DUR_CYC_20;
			misc_r    <= 10'h08A;    // Direct route and both grounds, as the reset codes decode
		end else begin
			gain_r    <= gain_nxt;
			bias_r    <= bias_nxt;
			pos_pin_r <= pos_pin_nxt;
			neg_pin_r <= neg_pin_nxt;
			dur_r     <= dur_nxt;
			misc_r    <= misc_nxt;
		end
	end

	// Port assignments, all from flip-flops
	assign s_axi_awready_o          = awready_r;
	assign s_axi_wready_o           = wready_r;
	assign s_axi_bvalid_o           = bvalid_r;
	assign s_axi_bresp_o            = bresp_r;
	assign s_axi_arready_o          = arready_r;
	assign s_axi_rvalid_o           = rvalid_r;
	assign s_axi_rdata_o            = rdata_r;
	assign s_axi_rresp_o            = rresp_r;
	assign conversion_start_o       = start_r;
	assign amp_gain_sel_o           = gain_r;
	assign amp_bias_current_sel_o   = bias_r;
	assign amp_sample_duration_o    = dur_r;
	assign amp_power_o              = misc_r[0];
	assign route_direct_o           = misc_r[1];
	assign route_amp_o              = misc_r[2];
	assign pos_gnd_o                = misc_r[3];
	assign pos_supply_div10_input_o = misc_r[4];
	assign pos_temp_sensor_input_o  = misc_r[5];
	assign pos_comparator_dac_ref_o = misc_r[6];
	assign neg_gnd_o                = misc_r[7];
	assign neg_supply_div10_input_o = misc_r[8];
	assign neg_comparator_dac_ref_o = misc_r[9];
	assign pos_analog_pin_inputs_o  = pos_pin_r;
	assign neg_analog_pin_inputs_o  = neg_pin_r;

	// Checks on the block's own behaviour
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	gain_decode_a: assert property (##1 amp_gain_sel_o == (($past(amp_ctrl_r[GAIN_MSB:GAIN_LSB]) < 3'h5) ? (5'h01 << $past(amp_ctrl_r[GAIN_MSB:GAIN_LSB])) : 5'h00))
		else $error("gain decode wrong");
	bias_decode_a: assert property (##1 amp_bias_current_sel_o == (4'h1 << $past(amp_ctrl_r[BIAS_MSB:BIAS_LSB])))
		else $error("bias decode wrong");
	dur_decode_a: assert property (##1 $past(amp_ctrl_r[DUR_MSB:DUR_LSB]) == 2'h3 |-> amp_sample_duration_o == 5'h00)
		else $error("reserved duration not blank");
	amp_power_a: assert property (amp_power_o |-> $past(amp_ctrl_r[0]) && ($past(via_r) == 2'h1 || $past(low_latency_ctrl_i)))
		else $error("amplifier powered without cause");
	route_excl_a: assert property (!(route_direct_o && route_amp_o))
		else $error("both routes selected");
	via_shared_a: assert property (wr_fire && wstrb0_r && (aw_idx_r == IDX_POS_SEL ||
		aw_idx_r == IDX_NEG_SEL) |=> via_r == $past(wbyte_r[VIA_MSB:VIA_LSB]))
		else $error("path field not shared");
	pos_temp_a: assert property (##1 pos_temp_sensor_input_o == ($past(pos_code_r) == 6'h32))
		else $error("temperature select wrong");
	neg_pin_a: assert property (##1 neg_analog_pin_inputs_o != 7'h00 |-> $past(neg_code_r) >= 6'h01 && $past(neg_code_r) <= 6'h07)
		else $error("negative pin select wrong");
	result_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o && ar_idx == IDX_RES1 |=> s_axi_rvalid_o && s_axi_rdata_o == {24'h000000, $past(result_r[15:8])})
		else $error("result byte one read wrong");
	sample_load_a: assert property (sample_valid_i |=> sample_r == $past(sample_data_i))
		else $error("sample not loaded");
	start_pulse_a: assert property (conversion_start_o |-> $past(wr_fire && aw_idx_r == IDX_POS_SEL && start_trigger_sel_i == 3'h2))
		else $error("start without positive selector write");
	write_answer_a: assert property (wr_fire |=> s_axi_bvalid_o)
		else $error("write not answered");
	amp_store_a: assert property (wr_fire && wstrb0_r && aw_idx_r == IDX_AMP_CTRL |=>
		amp_ctrl_r == $past(wbyte_r))
		else $error("control byte not stored as written");
	bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write answer dropped");
	write_seen_c: cover property (s_axi_awvalid_i && s_axi_awready_o ##1 s_axi_wvalid_i && s_axi_wready_o ##[1:3] s_axi_bvalid_o);
	start_seen_c: cover property (conversion_start_o);
	low_latency_ctrl_c:     cover property (amp_power_o && !route_amp_o);
	read_err_c:   cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h3);
endmodule // aamr_regs

// ==== dv/aamr_regs_tb.sv ====
// Self-checking bench for the amplifier, multiplexer and result register slice
`timescale 1ns/1ns
module aamr_regs_tb;
	import aamr_pkg::*;
	typedef struct packed {
		logic [7:0] ctl;
		logic [4:0] gain;
		logic [3:0] bias;
		logic [4:0] dur;
	} aamr_row_s;
	logic        clock_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        low_lat = 1'b0, res_v = 1'b0, smp_v = 1'b0;
	logic [2:0]  trig = 3'h0;
	logic [31:0] res_d = 32'h0;
	logic [15:0] smp_d = 16'h0;
	logic        awready, wready, bvalid, arready, rvalid, start, power, rdir, ramp;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [4:0]  gain, dur;
	logic [3:0]  bias;
	logic        pgnd, psup, ptmp, pdac, ngnd, nsup, ndac;
	logic [14:0] ppin;
	logic [6:0]  npin;
	int          failures = 0, samples_checked = 0, cycles = 0, starts = 0, i;
	// Amplifier control rows: every gain, bias and duration code, reserved ones too
	aamr_row_s   rows [8] = '{{8'h00, 5'h01, 4'h1, DUR_CYC_6}, {8'h2B, 5'h02, 4'h2, DUR_CYC_15},
		{8'h54, 5'h04, 4'h4, DUR_CYC_20}, {8'h7F, 5'h08, 4'h8, 5'h00}, {8'h80, 5'h10, 4'h1, DUR_CYC_6},
		{8'hA4, 5'h00, 4'h1, DUR_CYC_20}, {8'hCA, 5'h00, 4'h2, DUR_CYC_15}, {8'hFF, 5'h00, 4'h8, 5'h00}};
	logic [5:0]  pos_codes [10] = '{6'h00, 6'h01, 6'h0F, 6'h10, 6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h3F};
	logic [5:0]  neg_codes [8] = '{6'h00, 6'h01, 6'h07, 6'h08, 6'h30, 6'h31, 6'h32, 6'h33};

	aamr_regs u_aamr_regs (.clock_i(clock_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .low_latency_ctrl_i(low_lat),
		.start_trigger_sel_i(trig), .result_valid_i(res_v), .result_data_i(res_d),
		.sample_valid_i(smp_v), .sample_data_i(smp_d), .conversion_start_o(start),
		.amp_gain_sel_o(gain), .amp_bias_current_sel_o(bias), .amp_sample_duration_o(dur),
		.amp_power_o(power), .route_direct_o(rdir), .route_amp_o(ramp), .pos_gnd_o(pgnd),
		.pos_analog_pin_inputs_o(ppin), .pos_supply_div10_input_o(psup),
		.pos_temp_sensor_input_o(ptmp), .pos_comparator_dac_ref_o(pdac), .neg_gnd_o(ngnd),
		.neg_analog_pin_inputs_o(npin), .neg_supply_div10_input_o(nsup),
		.neg_comparator_dac_ref_o(ndac));

	// 125 MHz clock
	always #4 clock_i = ~clock_i;

	// Watchdog and start pulse counter; a hang ends the run as a mismatch
	always @(posedge clock_i) begin
		cycles++;
		if (start === 1'b1) starts++;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Write one register; valids drop at the edge their ready is seen, response waited for
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clock_i);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk(bresp, er);
		bready <= 1'b0;
	endtask

	// Read one register and compare data and response
	task automatic rdchk(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock_i);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock_i); while (rvalid !== 1'b1);
		chk(rdata, ed);
		chk(rresp, er);
		rready <= 1'b0;
	endtask

	// Decoded outputs lag the register by a clock; checks read pre-edge values
	task automatic settle();
		repeat (3) @(posedge clock_i);
	endtask

	task automatic do_reset();
		@(posedge clock_i);
		reset_n_i <= 1'b0;
		repeat (12) @(posedge clock_i);
		reset_n_i <= 1'b1;
		settle();
	endtask

	function automatic logic [18:0] pos_exp(input logic [5:0] c);
		pos_exp = '0;
		pos_exp[18] = (c == SEL_GND_DEFAULT) || (c == SEL_GND);
		if (c >= 6'h01 && c <= 6'h0F) pos_exp[17:3] = 15'h0001 << (c - 6'h01);
		pos_exp[2:0] = {c == SEL_SUPPLY, c == SEL_TEMP, c == SEL_DACREF};
	endfunction

	function automatic logic [9:0] neg_exp(input logic [5:0] c);
		neg_exp = '0;
		neg_exp[9] = (c == SEL_GND_DEFAULT) || (c == SEL_GND);
		if (c >= 6'h01 && c <= 6'h07) neg_exp[8:2] = 7'h01 << (c - 6'h01);
		neg_exp[1:0] = {c == SEL_SUPPLY, c == SEL_DACREF};
	endfunction

	initial begin
		repeat (12) @(posedge clock_i);
		reset_n_i <= 1'b1;
		settle();
		chk({rdir, ramp, pgnd, ngnd, power, start}, 6'h2C);
		chk({gain, bias, dur}, {5'h01, 4'h1, DUR_CYC_20});
		rdchk(IDX_AMP_CTRL, {24'h0, AMP_CTRL_RST}, RESP_OKAY);
		for (i = 0; i < 4; i++) rdchk(IDX_RES0 + 6'(i), 32'h0, RESP_OKAY);
		for (i = 0; i < 2; i++) rdchk(IDX_SAMP0 + 6'(i), 32'h0, RESP_OKAY);
		// Table of amplifier settings, reserved codes kept as written
		foreach (rows[k]) begin
			wr(IDX_AMP_CTRL, rows[k].ctl, 4'h1, RESP_OKAY);
			settle();
			chk({gain, bias, dur}, {rows[k].gain, rows[k].bias, rows[k].dur});
			rdchk(IDX_AMP_CTRL, {24'h0, rows[k].ctl}, RESP_OKAY);
		end
		foreach (pos_codes[k]) begin
			wr(IDX_POS_SEL, {2'b00, pos_codes[k]}, 4'h1, RESP_OKAY);
			settle();
			chk({pgnd, ppin, psup, ptmp, pdac}, pos_exp(pos_codes[k]));
		end
		foreach (neg_codes[k]) begin
			wr(IDX_NEG_SEL, {2'b00, neg_codes[k]}, 4'h1, RESP_OKAY);
			settle();
			chk({ngnd, npin, nsup, ndac}, neg_exp(neg_codes[k]));
		end
		chk(starts, 0);
		// Shared path field and amplifier power
		wr(IDX_AMP_CTRL, 8'h05, 4'h1, RESP_OKAY);
		wr(IDX_NEG_SEL, 8'h02, 4'h1, RESP_OKAY);
		wr(IDX_POS_SEL, 8'h41, 4'h1, RESP_OKAY);
		settle();
		rdchk(IDX_NEG_SEL, 32'h42, RESP_OKAY);
		chk({rdir, ramp, power}, 3'b011);
		wr(IDX_NEG_SEL, 8'h02, 4'h1, RESP_OKAY);
		settle();
		rdchk(IDX_POS_SEL, 32'h01, RESP_OKAY);
		chk({rdir, ramp, power}, 3'b100);
		low_lat <= 1'b1;
		settle();
		chk(power, 1'b1);
		wr(IDX_AMP_CTRL, 8'h04, 4'h1, RESP_OKAY);
		settle();
		chk(power, 1'b0);
		wr(IDX_NEG_SEL, 8'hC2, 4'h1, RESP_OKAY);
		settle();
		chk({rdir, ramp}, 2'b00);
		rdchk(IDX_POS_SEL, 32'hC1, RESP_OKAY);
		low_lat <= 1'b0;
		// Start on positive selector write only, and only with a real strobe
		trig <= START_POS_WRITE;
		wr(IDX_POS_SEL, 8'h03, 4'h1, RESP_OKAY);
		wr(IDX_NEG_SEL, 8'h03, 4'h1, RESP_OKAY);
		wr(IDX_POS_SEL, 8'h04, 4'h0, RESP_OKAY);
		settle();
		chk(starts, 1);
		trig <= 3'h3;
		wr(IDX_POS_SEL, 8'h05, 4'h1, RESP_OKAY);
		settle();
		chk(starts, 1);
		rdchk(IDX_POS_SEL, 32'h05, RESP_OKAY);
		// Conversion results land byte-wise, read-only
		res_d <= 32'hA1B2C3D4;
		res_v <= 1'b1;
		smp_d <= 16'h5AA5;
		smp_v <= 1'b1;
		@(posedge clock_i);
		res_v <= 1'b0;
		smp_v <= 1'b0;
		wr(IDX_RES1, 8'hFF, 4'h1, RESP_OKAY);
		wr(IDX_SAMP1, 8'hFF, 4'h1, RESP_OKAY);
		for (i = 0; i < 4; i++) rdchk(IDX_RES0 + 6'(i), 32'(res_d[8*i +: 8]), RESP_OKAY);
		rdchk(IDX_SAMP0, 32'hA5, RESP_OKAY);
		rdchk(IDX_SAMP1, 32'h5A, RESP_OKAY);
		wr(6'h3F, 8'h12, 4'h1, RESP_DECERR);
		rdchk(6'h3F, 32'h0, RESP_DECERR);
		// Reset in mid-run clears results and restores controls
		do_reset();
		rdchk(IDX_RES3, 32'h0, RESP_OKAY);
		rdchk(IDX_SAMP0, 32'h0, RESP_OKAY);
		rdchk(IDX_POS_SEL, 32'h0, RESP_OKAY);
		chk({rdir, dur}, {1'b1, DUR_CYC_20});
		tally_and_finish();
	end
endmodule // aamr_regs_tb
